// ### verilog/app_pkg.sv
// Shared constants and types for the converter parallel port and its host controller
package app_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 50;
  localparam int ACQ_NS = 135;
  localparam int ACQ_CYCLES = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYCLES = 14;
  localparam int PWRUP_CYCLES = 8;
  localparam int STROBE_CYCLES = 3;

  //////////////////////////////////////////////////////////////////////////////
  // Parallel bus layout
  localparam int DW = 12;
  localparam int HIGH_BYTE_ENABLE_POS = 8;
  localparam int HI_ZERO_POS = 4;
  localparam int CHAN_POS = 5;
  localparam logic [DW-1:0] OE_NONE = 12'h000;
  localparam logic [DW-1:0] OE_WORD = 12'hFFF;
  localparam logic [DW-1:0] OE_LOW8 = 12'h0FF;
  localparam logic [DW-1:0] OE_HIGH_BYTE_ENABLE = 12'h100;
  localparam logic [DW-1:0] OE_BYTE_WR = 12'h1FF;

  //////////////////////////////////////////////////////////////////////////////
  // Control register of the converter
  localparam logic [DW-1:0] CTRL_RESET = 12'h000;
  localparam int PM_UPPER_POS = 9;
  localparam int PM_LOWER_POS = 8;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_AUTO_SHDN = 2'h1;
  localparam logic [1:0] PM_AUTO_STBY = 2'h2;
  localparam logic [1:0] PM_FULL_SHDN = 2'h3;

  typedef enum logic [1:0] {PWR_ON, PWR_STANDBY, PWR_SHUTDOWN} app_pwr_e;

  //////////////////////////////////////////////////////////////////////////////
  // Host controller APB registers
  localparam logic [11:0] OFS_CFG = 12'h000;
  localparam logic [11:0] OFS_CMD = 12'h004;
  localparam logic [11:0] OFS_WDATA = 12'h008;
  localparam logic [11:0] OFS_RDATA = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam int CFG_WORD_POS = 0;
  localparam int CFG_CONVERT_START_N_POS = 1;
  localparam logic [1:0] CFG_RESET = 2'h3;
  localparam int CMD_READ_POS = 0;
  localparam int CMD_WRITE_POS = 1;
  localparam int RDATA_CHAN_POS = 12;
  localparam int STAT_ACTIVE_POS = 0;
  localparam int STAT_BUSY_POS = 1;
  localparam int STAT_GUARD_POS = 2;

endpackage : app_pkg

// ### verilog/app_if.sv
// Parallel port wiring between converter and host, with bus level resolution
`timescale 1ns/1ns
interface app_if;
  import app_pkg::*;

  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic convert_start_n;
  logic word_byte_select;
  logic busy;
  logic [DW-1:0] host_db_o;
  logic [DW-1:0] host_db_oe;
  logic [DW-1:0] dev_db_o;
  logic [DW-1:0] dev_db_oe;
  logic [DW-1:0] db;

  // Undriven lines float high through the board pull-ups
  assign db = (dev_db_oe & dev_db_o) | (~dev_db_oe & host_db_oe & host_db_o) |
              (~dev_db_oe & ~host_db_oe);

  modport dev (
    input cs_n, rd_n, wr_n, convert_start_n, word_byte_select, db,
    output busy, dev_db_o, dev_db_oe
  );

  modport host (
    output cs_n, rd_n, wr_n, convert_start_n, word_byte_select, host_db_o, host_db_oe,
    input busy, db
  );

endinterface : app_if

// ### verilog/app_adc_port.sv
// Converter end: parallel read/write port, control register and power modes
`timescale 1ns/1ns
module app_adc_port
  import app_pkg::*;
#(
  parameter int RES_BITS = 12,
  parameter int CONV_CYC = CONV_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Parallel port
  app_if.dev bus,
  // Sampled analog result
  input wire logic [DW-1:0] sample_word,
  input wire logic [1:0] sample_chan,
  // Converter state
  output logic [DW-1:0] ctrl_word,
  output app_pwr_e power_state,
  output logic tracking,
  output logic ref_powered,
  output logic conv_done
);

  localparam int CW = $clog2(CONV_CYC + 1);

  // Places a result on the 12-bit grid; the 10-bit part sits above two zeros
  function automatic logic [DW-1:0] align_result(input logic [DW-1:0] raw);
    if (RES_BITS == 10) begin
      align_result = {raw[9:0], 2'b00};
    end else begin
      align_result = raw;
    end
  endfunction : align_result

  // Builds one byte of a byte-mode read
  function automatic logic [7:0] read_half(input logic [DW-1:0] w, input logic [1:0] ch,
                                           input logic hi);
    logic [7:0] b;
    b = 8'h00;
    if (hi) begin
      b[3:0] = w[11:8];
      b[HI_ZERO_POS] = 1'b0;
      b[CHAN_POS +: 2] = ch;
    end else begin
      b = w[7:0];
    end
    read_half = b;
  endfunction : read_half

  logic busy_reg;
  logic [CW-1:0] cnt_reg;
  logic [DW-1:0] result_reg;
  logic [1:0] chan_reg;
  logic [DW-1:0] dout_reg;
  logic [DW-1:0] doe_reg;
  logic [DW-1:0] ctrl_reg;
  logic [7:0] low_hold_reg;
  logic [DW-1:0] wlat_reg;
  logic wr_act_q_reg;
  logic convert_start_n_q_reg;
  logic primed_reg;
  app_pwr_e pwr_reg;
  logic track_reg;
  logic done_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Strobe decode and edges

  logic rd_act;
  logic wr_act;
  logic wr_rise;
  logic conv_fall;
  logic conv_rise;
  logic eoc;
  logic start;

  assign rd_act = ~bus.cs_n & ~bus.rd_n;
  assign wr_act = ~bus.cs_n & ~bus.wr_n;
  assign wr_rise = wr_act_q_reg & ~wr_act;
  // No edge is believed in the first cycle after reset, the old level is unknown
  assign conv_fall = primed_reg & convert_start_n_q_reg & ~bus.convert_start_n;
  assign conv_rise = primed_reg & ~convert_start_n_q_reg & bus.convert_start_n;
  assign eoc = busy_reg && (cnt_reg == CW'(1));
  assign start = conv_fall && !busy_reg && (pwr_reg == PWR_ON);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_act_q_reg <= 1'b0;
      convert_start_n_q_reg <= 1'b1;
      primed_reg <= 1'b0;
    end else begin
      wr_act_q_reg <= wr_act;
      convert_start_n_q_reg <= bus.convert_start_n;
      primed_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion timing

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (start) begin
      busy_reg <= 1'b1;
      cnt_reg <= CW'(CONV_CYC);
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - CW'(1);
      if (cnt_reg == CW'(1)) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Result lands one cycle before busy falls so a tied-low read sees it in time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= '0;
      chan_reg <= 2'h0;
    end else if (busy_reg && (cnt_reg == CW'(2))) begin
      result_reg <= align_result(sample_word);
      chan_reg <= sample_chan;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= eoc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_reg <= '0;
      doe_reg <= OE_NONE;
    end else if (rd_act) begin
      if (bus.word_byte_select) begin
        dout_reg <= result_reg;
        doe_reg <= OE_WORD;
      end else begin
        dout_reg <= {4'h0, read_half(result_reg, chan_reg, bus.db[HIGH_BYTE_ENABLE_POS])};
        doe_reg <= OE_LOW8;
      end
    end else begin
      doe_reg <= OE_NONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write path

  logic commit;
  logic [DW-1:0] commit_word;
  logic [1:0] new_pm;
  logic [1:0] cur_pm;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wlat_reg <= '0;
    end else if (wr_act) begin
      wlat_reg <= bus.db;
    end
  end

  always_comb begin
    commit = 1'b0;
    commit_word = ctrl_reg;
    if (wr_rise) begin
      if (bus.word_byte_select) begin
        commit = 1'b1;
        commit_word = wlat_reg;
      end else if (wlat_reg[HIGH_BYTE_ENABLE_POS]) begin
        commit = 1'b1;
        commit_word = {wlat_reg[3:0], low_hold_reg};
      end
    end
  end

  // The lower byte waits here; a lone lower byte changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_hold_reg <= 8'h00;
    end else if (wr_rise && !bus.word_byte_select && !wlat_reg[HIGH_BYTE_ENABLE_POS]) begin
      low_hold_reg <= wlat_reg[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (commit) begin
      ctrl_reg <= commit_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power management and track-and-hold

  assign new_pm = {commit_word[PM_UPPER_POS], commit_word[PM_LOWER_POS]};
  assign cur_pm = {ctrl_reg[PM_UPPER_POS], ctrl_reg[PM_LOWER_POS]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= PWR_ON;
      track_reg <= 1'b0;
    end else if (commit && (new_pm == PM_FULL_SHDN)) begin
      pwr_reg <= PWR_SHUTDOWN;
      track_reg <= 1'b0;
    end else if (commit && (cur_pm == PM_FULL_SHDN)) begin
      pwr_reg <= PWR_ON;
      track_reg <= 1'b1;
    end else if (eoc) begin
      case (cur_pm)
        PM_NORMAL: begin
          track_reg <= 1'b1;
        end
        PM_AUTO_SHDN: begin
          pwr_reg <= PWR_SHUTDOWN;
          track_reg <= 1'b0;
        end
        PM_AUTO_STBY: begin
          pwr_reg <= PWR_STANDBY;
          track_reg <= 1'b0;
        end
        default: begin
          pwr_reg <= PWR_SHUTDOWN;
          track_reg <= 1'b0;
        end
      endcase
    end else if (start) begin
      track_reg <= 1'b0;
    end else if (conv_rise && !busy_reg && (cur_pm != PM_FULL_SHDN)) begin
      pwr_reg <= PWR_ON;
      track_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus.busy = busy_reg;
  assign bus.dev_db_o = dout_reg;
  assign bus.dev_db_oe = doe_reg;
  assign ctrl_word = ctrl_reg;
  assign power_state = pwr_reg;
  assign tracking = track_reg;
  assign conv_done = done_reg;

  // The reference stays up in standby only; full shutdown drops it too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_powered <= 1'b1;
    end else begin
      ref_powered <= (pwr_reg != PWR_SHUTDOWN);
    end
  end

endmodule : app_adc_port

// ### verilog/app_host.sv
// Host end: APB-programmed controller driving the converter parallel port
`timescale 1ns/1ns
module app_host
  import app_pkg::*;
#(
  parameter int PWRUP = PWRUP_CYCLES,
  parameter int STROBE = STROBE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parallel port
  app_if.host bus
);

  localparam int GUARD = (PWRUP > ACQ_CYCLES) ? PWRUP : ACQ_CYCLES;
  localparam int GW = $clog2(GUARD + 1);
  localparam int SW = $clog2(STROBE + 1);

  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD} app_hst_e;

  app_hst_e st_reg;
  logic op_read_reg;
  logic half_reg;
  logic [SW-1:0] scnt_reg;
  logic cs_n_reg;
  logic rd_n_reg;
  logic wr_n_reg;
  logic [DW-1:0] db_o_reg;
  logic [DW-1:0] db_oe_reg;
  logic [DW-1:0] rdata_reg;
  logic [1:0] chan_reg;
  logic [DW-1:0] wdata_reg;
  logic word_reg;
  logic convert_start_n_req_reg;
  logic convert_start_n_n_reg;
  logic [GW-1:0] guard_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, one registered wait-free answer per access

  logic wr_en;
  logic go_rd;
  logic go_wr;
  logic mapped;
  logic [31:0] rmux;
  logic wr_done;

  assign wr_en = psel & penable & pready_reg & pwrite;
  assign go_rd = wr_en && (paddr == OFS_CMD) && pwdata[CMD_READ_POS] && (st_reg == HS_IDLE);
  assign go_wr = wr_en && (paddr == OFS_CMD) && !pwdata[CMD_READ_POS] &&
                 pwdata[CMD_WRITE_POS] && (st_reg == HS_IDLE);
  assign wr_done = (st_reg == HS_HOLD) && !op_read_reg && (word_reg || half_reg);

  always_comb begin
    rmux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      OFS_CFG: begin
        rmux[CFG_WORD_POS] = word_reg;
        rmux[CFG_CONVERT_START_N_POS] = convert_start_n_req_reg;
      end
      OFS_CMD: begin
      end
      OFS_WDATA: rmux[DW-1:0] = wdata_reg;
      OFS_RDATA: rmux = {18'h0_0000, chan_reg, rdata_reg};
      OFS_STATUS: begin
        rmux[STAT_ACTIVE_POS] = (st_reg != HS_IDLE);
        rmux[STAT_BUSY_POS] = bus.busy;
        rmux[STAT_GUARD_POS] = (guard_reg != '0);
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & ~penable;
      if (psel && !penable) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rmux;
        pslverr_reg <= ~mapped;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg <= CFG_RESET[CFG_WORD_POS];
      convert_start_n_req_reg <= CFG_RESET[CFG_CONVERT_START_N_POS];
      wdata_reg <= '0;
    end else if (wr_en) begin
      if (paddr == OFS_CFG) begin
        word_reg <= pwdata[CFG_WORD_POS];
        convert_start_n_req_reg <= pwdata[CFG_CONVERT_START_N_POS];
      end
      if (paddr == OFS_WDATA) begin
        wdata_reg <= pwdata[DW-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= HS_IDLE;
      op_read_reg <= 1'b0;
      half_reg <= 1'b0;
      scnt_reg <= '0;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      db_o_reg <= '0;
      db_oe_reg <= OE_NONE;
      rdata_reg <= '0;
      chan_reg <= 2'h0;
    end else begin
      case (st_reg)
        HS_IDLE: begin
          if (go_rd || go_wr) begin
            op_read_reg <= go_rd;
            half_reg <= 1'b0;
            cs_n_reg <= 1'b0;
            st_reg <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          scnt_reg <= '0;
          st_reg <= HS_STROBE;
          // Only one strobe at a time joins the select
          rd_n_reg <= ~op_read_reg;
          wr_n_reg <= op_read_reg;
          if (word_reg) begin
            db_o_reg <= wdata_reg;
            db_oe_reg <= op_read_reg ? OE_NONE : OE_WORD;
          end else if (half_reg) begin
            db_o_reg <= {3'h0, 1'b1, 4'h0, wdata_reg[11:8]};
            db_oe_reg <= op_read_reg ? OE_HIGH_BYTE_ENABLE : OE_BYTE_WR;
          end else begin
            db_o_reg <= {3'h0, 1'b0, wdata_reg[7:0]};
            db_oe_reg <= op_read_reg ? OE_HIGH_BYTE_ENABLE : OE_BYTE_WR;
          end
        end
        HS_STROBE: begin
          scnt_reg <= scnt_reg + SW'(1);
          if (scnt_reg == SW'(STROBE - 1)) begin
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            st_reg <= HS_HOLD;
            if (op_read_reg) begin
              if (word_reg) begin
                rdata_reg <= bus.db;
              end else if (half_reg) begin
                rdata_reg[11:8] <= bus.db[3:0];
                chan_reg <= bus.db[CHAN_POS +: 2];
              end else begin
                rdata_reg[7:0] <= bus.db[7:0];
              end
            end
          end
        end
        HS_HOLD: begin
          db_oe_reg <= OE_NONE;
          if (!word_reg && !half_reg) begin
            half_reg <= 1'b1;
            st_reg <= HS_SETUP;
          end else begin
            cs_n_reg <= 1'b1;
            st_reg <= HS_IDLE;
          end
        end
        default: begin
          st_reg <= HS_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Start line with power-up guard; a low request is held off until it expires

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      convert_start_n_n_reg <= 1'b1;
      guard_reg <= '0;
    end else if (convert_start_n_req_reg && !convert_start_n_n_reg) begin
      convert_start_n_n_reg <= 1'b1;
      guard_reg <= GW'(GUARD);
    end else if (wr_done) begin
      guard_reg <= GW'(GUARD);
    end else if (guard_reg != '0) begin
      guard_reg <= guard_reg - GW'(1);
    end else if (!convert_start_n_req_reg) begin
      convert_start_n_n_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bus.cs_n = cs_n_reg;
  assign bus.rd_n = rd_n_reg;
  assign bus.wr_n = wr_n_reg;
  assign bus.convert_start_n = convert_start_n_n_reg;
  assign bus.word_byte_select = word_reg;
  assign bus.host_db_o = db_o_reg;
  assign bus.host_db_oe = db_oe_reg;

endmodule : app_host

// ### testbench/app_port_assertions.sv
// Protocol checks on the converter parallel port lines
`timescale 1ns/1ns
module app_port_assertions
  import app_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Port lines
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic convert_start_n,
  input wire logic word_byte_select,
  input wire logic busy,
  input wire logic [DW-1:0] host_db_oe,
  input wire logic [DW-1:0] dev_db_o,
  input wire logic [DW-1:0] dev_db_oe,
  input wire logic [DW-1:0] db
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////
  // Fourteen busy cycles, then low
  sequence conv_s;
    busy[*8] ##1 busy[*6] ##1 !busy;
  endsequence
  sequence start_s;
    $fell(convert_start_n) && !busy;
  endsequence

  conv_busy_a: assert property (start_s |=> conv_s)
    else $error("busy length wrong after start fall");
  strobe_excl_a: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  bus_drive_a: assert property ((|dev_db_oe) == $past(!cs_n && !rd_n))
    else $error("device drive not tied to select and read");
  word_lanes_a: assert property (|dev_db_oe && word_byte_select |-> dev_db_oe == OE_WORD)
    else $error("word read lanes wrong");
  byte_lanes_a: assert property (|dev_db_oe && !word_byte_select |-> dev_db_oe == OE_LOW8)
    else $error("byte read lanes wrong");
  high_half_a: assert property (|dev_db_oe && !word_byte_select && db[HIGH_BYTE_ENABLE_POS]
    |-> dev_db_o[HI_ZERO_POS] == 1'b0 && dev_db_o[7] == 1'b0)
    else $error("high half zero bits wrong");
  write_lanes_a: assert property (!wr_n
    |-> host_db_oe == (word_byte_select ? OE_WORD : OE_BYTE_WR))
    else $error("write lanes wrong");
  upper_zero_a: assert property (!wr_n && !word_byte_select && db[HIGH_BYTE_ENABLE_POS]
    |-> db[7:4] == 4'h0)
    else $error("upper half top bits not zero");
  start_guard_a: assert property ($rose(convert_start_n) |-> convert_start_n[*3])
    else $error("start fell inside power-up guard");
endmodule : app_port_assertions

// ### testbench/adc_parallel_port_power_modes_test.sv
// Self-checking bench: APB host controller driving the converter port
`timescale 1ns/1ns
module adc_parallel_port_power_modes_test
  import app_pkg::*;
();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, err, tracking, conv_done, ref_on;
  logic [DW-1:0] sample_word = 12'h000, ctrl_word;
  logic [1:0] sample_chan = 2'h0;
  app_pwr_e power_state;
  int n_errors = 0, samples_checked = 0, cycles = 0;

  always #25 pclk = ~pclk;
  app_if u_app_if ();
  // Short guard keeps the run brief; still covers the acquisition time
  app_host #(.PWRUP(3), .STROBE(STROBE_CYCLES)) u_app_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(u_app_if.host));
  app_adc_port #(.RES_BITS(12), .CONV_CYC(CONV_CYCLES)) u_app_adc_port (.pclk(pclk),
    .presetn(presetn), .bus(u_app_if.dev), .sample_word(sample_word),
    .sample_chan(sample_chan), .ctrl_word(ctrl_word), .power_state(power_state),
    .tracking(tracking), .ref_powered(ref_on), .conv_done(conv_done));
  app_port_assertions u_app_port_assertions (.pclk(pclk), .presetn(presetn),
    .cs_n(u_app_if.cs_n), .rd_n(u_app_if.rd_n), .wr_n(u_app_if.wr_n),
    .convert_start_n(u_app_if.convert_start_n), .word_byte_select(u_app_if.word_byte_select),
    .busy(u_app_if.busy), .host_db_oe(u_app_if.host_db_oe), .dev_db_o(u_app_if.dev_db_o),
    .dev_db_oe(u_app_if.dev_db_oe), .db(u_app_if.db));

  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp

  // Waits for pready with no limit of its own; the hang guard ends a stuck wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Port transfer through the sequencer; r ends holding the read result
  task automatic port(input logic w, input logic [11:0] d);
    apb(1'b1, OFS_WDATA, {20'h0, d});
    apb(1'b1, OFS_CMD, w ? 32'h2 : 32'h1);
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end while (r[STAT_ACTIVE_POS] !== 1'b0);
    apb(1'b0, OFS_RDATA, 32'h0);
  endtask : port

  // Low level converts once; start stays low after, as auto modes want
  task automatic start(input logic lvl, input logic wm);
    apb(1'b1, OFS_CFG, {30'h0, lvl, wm});
    if (!lvl) begin
      do begin
        @(posedge pclk);
      end while (conv_done !== 1'b1);
    end
    repeat (3) @(posedge pclk);
  endtask : start

  task automatic pwr(input app_pwr_e p, input logic trk);
    cmp("power state", {30'h0, p}, {30'h0, power_state});
    cmp("tracking", {31'h0, trk}, {31'h0, tracking});
  endtask : pwr

  initial begin
    repeat (20) @(posedge pclk);
    cmp("ctrl reset", {20'h0, CTRL_RESET}, {20'h0, ctrl_word});
    cmp("ref powered", 32'h1, {31'h0, ref_on});
    pwr(PWR_ON, 1'b0);
    presetn <= 1'b1;
    apb(1'b0, 12'hFFC, 32'h0);
    cmp("unmapped read", 32'h0, r);
    cmp("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, OFS_CFG, 32'h0);
    cmp("cfg reset", {30'h0, CFG_RESET}, r);
    $display("test reset done");
    sample_word <= 12'hABC;
    sample_chan <= 2'h2;
    port(1'b1, 12'hCA5);
    cmp("word write", 32'hCA5, {20'h0, ctrl_word});
    start(1'b0, 1'b1);
    pwr(PWR_ON, 1'b1);
    start(1'b1, 1'b1);
    port(1'b0, 12'h000);
    cmp("word read", 32'hABC, {20'h0, r[11:0]});
    $display("test word mode done");
    port(1'b1, 12'h1A5);
    start(1'b0, 1'b1);
    pwr(PWR_SHUTDOWN, 1'b0);
    cmp("ref in shutdown", 32'h0, {31'h0, ref_on});
    cmp("ctrl kept", 32'h1A5, {20'h0, ctrl_word});
    start(1'b1, 1'b1);
    pwr(PWR_ON, 1'b1);
    port(1'b1, 12'h2A5);
    start(1'b0, 1'b1);
    pwr(PWR_STANDBY, 1'b0);
    cmp("ref in standby", 32'h1, {31'h0, ref_on});
    start(1'b1, 1'b1);
    pwr(PWR_ON, 1'b1);
    port(1'b1, 12'h3A5);
    pwr(PWR_SHUTDOWN, 1'b0);
    port(1'b1, 12'h0A5);
    pwr(PWR_ON, 1'b1);
    $display("test power modes done");
    apb(1'b1, OFS_CFG, 32'h2);
    port(1'b1, 12'hCC3);
    cmp("byte write", 32'hCC3, {20'h0, ctrl_word});
    sample_word <= 12'h5E7;
    sample_chan <= 2'h3;
    start(1'b0, 1'b0);
    start(1'b1, 1'b0);
    port(1'b0, 12'h000);
    cmp("low byte", 32'hE7, {24'h0, r[7:0]});
    cmp("byte read", 32'h35E7, r);
    $display("test byte mode done");
    conclude();
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      $display("CHECK FAILED timeout expected finish seen hang");
      conclude();
    end
  end
endmodule : adc_parallel_port_power_modes_test
